// File: core/fptc_ctrl.sv
// Purpose: flash array with erase/program, timing and block protection
// Assumes: one read and one modify request port; requests held until ack
// Notes: the array is modelled as a memory of 32-bit words
//
// Notes on behaviour
// - flash erases in 1-KB blocks; erase sets every bit to one.
// - program writes one 32-bit word, only clearing ones to zeros.
// - protection per 2-KB block, one program and one read bit each.
// - protection bits live in four program/read 32-bit register pairs.
// - program-enable one allows program/erase; zero leaves contents unchanged.
// - read-enable zero refuses data reads, still allowing instruction fetch.
// - both zero: execute-only, fetch only, no program or erase.
// - program zero, read one: read-only, modify requests refused.
// - program one, read zero: modify and fetch allowed, data read refused.
// - blocked modify raises interrupt only when violation mask is set.
// - refused data read returns zero, optional interrupt.
// - program/erase timing derived from cycles-per-microsecond reload.
// - clears act now, become permanent only on commit.
// - uncommitted clears revert on power-on reset.
// - protection writes only clear bits; setting back has no effect.
`default_nettype none
module fptc_ctrl
  import fptc_pkg::*;
#(
  parameter int unsigned ADDR_W = FPTC_ADDR_W,
  parameter int unsigned NPAIRS = FPTC_NPAIRS
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire fptc_rd_req_s rd_req,
  output logic rd_ack,
  output logic [31:0] rd_data,
  output logic rd_refused,
  input wire fptc_mod_req_s mod_req,
  output logic mod_ack,
  output logic mod_refused,
  output logic mod_busy,
  input wire logic us_reload_we,
  input wire logic [7:0] us_reload_wdata,
  output logic [7:0] us_cycle_reload,
  input wire logic prot_we,
  input wire logic prot_read_sel,
  input wire logic [1:0] prot_idx,
  input wire logic [31:0] prot_wdata,
  input wire logic commit_trigger,
  output logic commit_busy,
  output logic [NPAIRS*32-1:0] program_enable_mask,
  output logic [NPAIRS*32-1:0] read_enable_mask,
  input wire logic access_violation_irq_mask,
  input wire logic read_violation_irq_mask,
  output logic flash_irq
);
  localparam int unsigned NWORDS = 1 << (ADDR_W - 2);
  localparam int unsigned WPB = 1 << (FPTC_ERASE_LSB - 2);
  localparam int unsigned BW = ADDR_W - FPTC_ERASE_LSB;

  typedef enum {
    FPTC_ST_IDLE, FPTC_ST_WAIT, FPTC_ST_ERASE, FPTC_ST_DONE
  } fptc_st_e;

  logic [31:0] mem [NWORDS];
  fptc_st_e st_r, st_nxt;
  logic [7:0] usec_r, usec_nxt;
  logic [ADDR_W-1:0] op_addr_r, op_addr_nxt;
  logic [31:0] op_data_r, op_data_nxt;
  fptc_op_e op_r, op_nxt;
  logic [FPTC_ERASE_LSB-3:0] er_cnt_r, er_cnt_nxt;
  logic rd_ack_r, rd_ack_nxt;
  logic [31:0] rd_data_r, rd_data_nxt;
  logic rd_ref_r, rd_ref_nxt;
  logic mod_ack_r, mod_ack_nxt;
  logic mod_ref_r, mod_ref_nxt;
  logic irq_r, irq_nxt;
  logic tmr_start, tmr_busy, tmr_done;
  logic [15:0] tmr_us;
  logic wr_en;
  logic [ADDR_W-3:0] wr_word;
  logic [31:0] wr_val;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic prot_bit(input logic [NPAIRS*32-1:0] mask,
                                    input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] idx;
    idx = a >> FPTC_PROT_LSB;
    if (idx < ADDR_W'(NPAIRS * 32)) begin
      prot_bit = mask[idx[$clog2(NPAIRS*32)-1:0]];
    end else begin
      prot_bit = 1'b0;
    end
  endfunction : prot_bit

  function automatic logic [ADDR_W-3:0] word_of(input logic [ADDR_W-1:0] a);
    word_of = a[ADDR_W-1:2];
  endfunction : word_of

  // ------------------------------------------------------------
  // protection registers and timer
  // ------------------------------------------------------------
  fptc_prot_regs #(
    .NPAIRS(NPAIRS)
  ) u_prot (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .ce(ce),
    .wr_en(prot_we),
    .wr_read_sel(prot_read_sel),
    .wr_idx(prot_idx),
    .wr_data(prot_wdata),
    .commit_trigger(commit_trigger),
    .commit_busy(commit_busy),
    .program_enable_mask(program_enable_mask),
    .read_enable_mask(read_enable_mask)
  );

  fptc_us_timer u_tmr (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .ce(ce),
    .start(tmr_start),
    .n_us(tmr_us),
    .reload(usec_r),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_comb begin
    rd_ack_nxt = 1'b0;
    rd_data_nxt = rd_data_r;
    rd_ref_nxt = 1'b0;
    if (rd_req.valid && !rd_ack_r) begin
      rd_ack_nxt = 1'b1;
      if (rd_req.fetch || prot_bit(read_enable_mask, rd_req.addr)) begin
        rd_data_nxt = mem[word_of(rd_req.addr)];
      end else begin
        rd_data_nxt = FPTC_ZERO_WORD;
        rd_ref_nxt = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // modify sequencer
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    op_addr_nxt = op_addr_r;
    op_data_nxt = op_data_r;
    er_cnt_nxt = er_cnt_r;
    mod_ack_nxt = 1'b0;
    mod_ref_nxt = 1'b0;
    tmr_start = 1'b0;
    tmr_us = FPTC_PROG_US_W;
    wr_en = 1'b0;
    wr_word = word_of(op_addr_r);
    wr_val = op_data_r;
    unique case (st_r)
      FPTC_ST_IDLE: begin
        if (mod_req.valid && mod_req.op != FPTC_OP_NONE) begin
          op_nxt = mod_req.op;
          op_addr_nxt = mod_req.addr;
          op_data_nxt = mod_req.data;
          if (!prot_bit(program_enable_mask, mod_req.addr)) begin
            mod_ack_nxt = 1'b1;
            mod_ref_nxt = 1'b1;
            st_nxt = FPTC_ST_DONE;
          end else begin
            tmr_start = 1'b1;
            tmr_us = (mod_req.op == FPTC_OP_ERASE) ? FPTC_ERASE_US_W
                                                   : FPTC_PROG_US_W;
            st_nxt = FPTC_ST_WAIT;
          end
        end
      end
      FPTC_ST_WAIT: begin
        if (tmr_done) begin
          if (op_r == FPTC_OP_ERASE) begin
            er_cnt_nxt = '0;
            st_nxt = FPTC_ST_ERASE;
          end else begin
            wr_en = 1'b1;
            wr_val = mem[word_of(op_addr_r)] & op_data_r;
            mod_ack_nxt = 1'b1;
            st_nxt = FPTC_ST_DONE;
          end
        end
      end
      FPTC_ST_ERASE: begin
        wr_en = 1'b1;
        wr_word = {op_addr_r[ADDR_W-1:FPTC_ERASE_LSB], er_cnt_r};
        wr_val = FPTC_ERASED_WORD;
        er_cnt_nxt = er_cnt_r + 1'b1;
        if (er_cnt_r == (FPTC_ERASE_LSB-2)'(WPB - 1)) begin
          mod_ack_nxt = 1'b1;
          st_nxt = FPTC_ST_DONE;
        end
      end
      FPTC_ST_DONE: begin
        if (!mod_req.valid) begin
          st_nxt = FPTC_ST_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    usec_nxt = us_reload_we ? us_reload_wdata : usec_r;
    irq_nxt = (mod_ref_r && access_violation_irq_mask) ||
              (rd_ref_r && read_violation_irq_mask);
  end

  always_ff @(posedge clk_sys) begin
    if (ce && wr_en) begin
      mem[wr_word] <= wr_val;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= FPTC_ST_IDLE;
      op_r <= FPTC_OP_NONE;
      op_addr_r <= '0;
      op_data_r <= '0;
      er_cnt_r <= '0;
      usec_r <= FPTC_USEC_RESET;
      rd_ack_r <= 1'b0;
      rd_data_r <= '0;
      rd_ref_r <= 1'b0;
      mod_ack_r <= 1'b0;
      mod_ref_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      op_addr_r <= op_addr_nxt;
      op_data_r <= op_data_nxt;
      er_cnt_r <= er_cnt_nxt;
      usec_r <= usec_nxt;
      rd_ack_r <= rd_ack_nxt;
      rd_data_r <= rd_data_nxt;
      rd_ref_r <= rd_ref_nxt;
      mod_ack_r <= mod_ack_nxt;
      mod_ref_r <= mod_ref_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign rd_ack = rd_ack_r;
  assign rd_data = rd_data_r;
  assign rd_refused = rd_ref_r;
  assign mod_ack = mod_ack_r;
  assign mod_refused = mod_ref_r;
  assign mod_busy = (st_r != FPTC_ST_IDLE) | tmr_busy;
  assign us_cycle_reload = usec_r;
  assign flash_irq = irq_r;
endmodule : fptc_ctrl
`default_nettype wire

// File: core/fptc_prot_regs.sv
// Purpose: four program/read protection register pairs, volatile and committed
// Assumes: the committed copy models the nonvolatile store
// Notes: writes only clear bits; commit makes clears permanent
`default_nettype none
module fptc_prot_regs
  import fptc_pkg::*;
#(
  parameter int unsigned NPAIRS = FPTC_NPAIRS
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic wr_read_sel,
  input wire logic [1:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic commit_trigger,
  output logic commit_busy,
  output logic [NPAIRS*32-1:0] program_enable_mask,
  output logic [NPAIRS*32-1:0] read_enable_mask
);
  // committed store survives reset; volatile copy reloads from it
  logic [31:0] nv_prg_r [NPAIRS] = '{default: FPTC_PROT_RESET};
  logic [31:0] nv_rde_r [NPAIRS] = '{default: FPTC_PROT_RESET};
  logic [31:0] prg_r [NPAIRS];
  logic [31:0] rde_r [NPAIRS];
  logic [31:0] prg_nxt [NPAIRS];
  logic [31:0] rde_nxt [NPAIRS];
  logic [31:0] nv_prg_nxt [NPAIRS];
  logic [31:0] nv_rde_nxt [NPAIRS];
  logic reload_r, commit_r;

  // ------------------------------------------------------------
  // volatile and committed next values
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NPAIRS; i++) begin
      prg_nxt[i] = reload_r ? nv_prg_r[i] : prg_r[i];
      rde_nxt[i] = reload_r ? nv_rde_r[i] : rde_r[i];
      nv_prg_nxt[i] = nv_prg_r[i];
      nv_rde_nxt[i] = nv_rde_r[i];
      if (wr_en && !reload_r && wr_idx == i[1:0]) begin
        if (wr_read_sel) begin
          rde_nxt[i] = rde_r[i] & wr_data;
        end else begin
          prg_nxt[i] = prg_r[i] & wr_data;
        end
      end
      if (commit_r) begin
        nv_prg_nxt[i] = nv_prg_r[i] & prg_r[i];
        nv_rde_nxt[i] = nv_rde_r[i] & rde_r[i];
      end
    end
  end

  // nonvolatile copy: only a power-on style first fill, never reset-cleared
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      for (int i = 0; i < NPAIRS; i++) begin
        nv_prg_r[i] <= nv_prg_nxt[i];
        nv_rde_r[i] <= nv_rde_nxt[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reload_r <= 1'b1;
      commit_r <= 1'b0;
      for (int i = 0; i < NPAIRS; i++) begin
        prg_r[i] <= FPTC_PROT_RESET;
        rde_r[i] <= FPTC_PROT_RESET;
      end
    end else if (ce) begin
      reload_r <= 1'b0;
      commit_r <= commit_trigger && !reload_r;
      for (int i = 0; i < NPAIRS; i++) begin
        prg_r[i] <= prg_nxt[i];
        rde_r[i] <= rde_nxt[i];
      end
    end
  end

  assign commit_busy = commit_r | reload_r;

  always_comb begin
    for (int i = 0; i < NPAIRS; i++) begin
      program_enable_mask[i*32 +: 32] = prg_r[i];
      read_enable_mask[i*32 +: 32] = rde_r[i];
    end
  end
endmodule : fptc_prot_regs
`default_nettype wire

// File: core/fptc_us_timer.sv
// Purpose: counts microseconds from a cycles-per-microsecond reload value
// Assumes: reload holds cycles-per-microsecond minus one
// Notes: done pulses once after the requested number of microseconds
`default_nettype none
module fptc_us_timer
  import fptc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic [15:0] n_us,
  input wire logic [7:0] reload,
  output logic busy,
  output logic done
);
  logic [7:0] cyc_r, cyc_nxt;
  logic [15:0] us_r, us_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;

  // ------------------------------------------------------------
  // microsecond counting
  // ------------------------------------------------------------
  always_comb begin
    cyc_nxt = cyc_r;
    us_nxt = us_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (start && !busy_r) begin
      cyc_nxt = reload;
      us_nxt = (n_us == 16'h0000) ? 16'h0001 : n_us;
      busy_nxt = 1'b1;
    end else if (busy_r) begin
      if (cyc_r != 8'h00) begin
        cyc_nxt = cyc_r - 8'h01;
      end else if (us_r == 16'h0001) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        us_nxt = us_r - 16'h0001;
        cyc_nxt = reload;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cyc_r <= 8'h00;
      us_r <= 16'h0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (ce) begin
      cyc_r <= cyc_nxt;
      us_r <= us_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy = busy_r;
  assign done = done_r;
endmodule : fptc_us_timer
`default_nettype wire

// File: include/fptc_pkg.sv
// Purpose: shared constants and carriers for the flash protect/timing block
// Assumes: 32-bit words, 1-KB erase blocks, 2-KB protect blocks
// Notes: protection registers are four program/read pairs
`default_nettype none
package fptc_pkg;
  localparam int unsigned FPTC_ADDR_W = 18;
  localparam int unsigned FPTC_WORD_W = 32;
  localparam int unsigned FPTC_ERASE_LSB = 10;
  localparam int unsigned FPTC_PROT_LSB = 11;
  localparam int unsigned FPTC_NPAIRS = 4;
  localparam int unsigned FPTC_NBLK = FPTC_NPAIRS * FPTC_WORD_W;
  localparam logic [31:0] FPTC_PROT_RESET = 32'hffff_ffff;
  localparam logic [31:0] FPTC_ERASED_WORD = 32'hffff_ffff;
  localparam logic [31:0] FPTC_ZERO_WORD = 32'h0000_0000;
  localparam logic [7:0] FPTC_USEC_RESET = 8'h31;
  localparam int unsigned FPTC_CLK_MHZ = 20;
  localparam int unsigned FPTC_PROG_US = 20;
  localparam int unsigned FPTC_ERASE_US = 40;
  localparam logic [15:0] FPTC_PROG_US_W = 16'h0014;
  localparam logic [15:0] FPTC_ERASE_US_W = 16'h0028;

  typedef enum logic [1:0] {
    FPTC_OP_NONE, FPTC_OP_PROG, FPTC_OP_ERASE
  } fptc_op_e;

  typedef struct packed {
    logic valid;
    logic fetch;
    logic [FPTC_ADDR_W-1:0] addr;
  } fptc_rd_req_s;

  typedef struct packed {
    logic valid;
    fptc_op_e op;
    logic [FPTC_ADDR_W-1:0] addr;
    logic [FPTC_WORD_W-1:0] data;
  } fptc_mod_req_s;
endpackage : fptc_pkg
`default_nettype wire

// File: tb/fptc_bus_model.sv
// Purpose: core and debugger side requester for fetch, read and modify
// Assumes: requests held until ack, dropped the half cycle after
// Notes: released address and data show inverted values
`default_nettype none
module fptc_bus_model
  import fptc_pkg::*;
(
  input wire logic clk_sys,
  output var fptc_rd_req_s rd_req,
  input wire logic rd_ack,
  input wire logic [31:0] rd_data,
  input wire logic rd_refused,
  output var fptc_mod_req_s mod_req,
  input wire logic mod_ack,
  input wire logic mod_refused
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rd_req = '0;
    mod_req = '0;
  end
  task automatic rd(input logic f, input logic [17:0] a, input int lag,
                    output logic [31:0] d, output logic r);
    repeat (lag) @(negedge clk_sys);
    @(negedge clk_sys);
    rd_req <= {1'b1, f, a};
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      #1;
      if (rd_ack) break;
    end
    d = rd_ack ? rd_data : 'x;
    r = rd_ack ? rd_refused : 1'bx;
    @(negedge clk_sys);
    rd_req <= {1'b0, ~f, ~a};
  endtask : rd
  task automatic md(input fptc_op_e op, input logic [17:0] a,
                    input logic [31:0] dt, output logic r, output int n);
    @(negedge clk_sys);
    mod_req <= {1'b1, op, a, dt};
    r = 1'bx;
    for (n = 1; n < 3000; n++) begin
      @(posedge clk_sys);
      #1;
      if (mod_ack) break;
    end
    if (mod_ack) r = mod_refused;
    @(negedge clk_sys);
    mod_req <= {1'b0, FPTC_OP_NONE, ~a, ~dt};
  endtask : md
endmodule : fptc_bus_model
`default_nettype wire

// File: tb/fptc_ctrl_assertions.sv
// Purpose: port checks for the flash protect/timing block
// Assumes: ce held high, requests dropped between transfers
// Notes: bound into every fptc_ctrl
`default_nettype none
module fptc_ctrl_assertions
  import fptc_pkg::*;
#(
  parameter int unsigned ADDR_W = FPTC_ADDR_W,
  parameter int unsigned NPAIRS = FPTC_NPAIRS
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire fptc_rd_req_s rd_req,
  input wire logic rd_ack,
  input wire logic [31:0] rd_data,
  input wire logic rd_refused,
  input wire fptc_mod_req_s mod_req,
  input wire logic mod_ack,
  input wire logic mod_refused,
  input wire logic us_reload_we,
  input wire logic [7:0] us_reload_wdata,
  input wire logic [7:0] us_cycle_reload,
  input wire logic prot_we,
  input wire logic prot_read_sel,
  input wire logic [1:0] prot_idx,
  input wire logic [31:0] prot_wdata,
  input wire logic [NPAIRS*32-1:0] program_enable_mask,
  input wire logic [NPAIRS*32-1:0] read_enable_mask,
  input wire logic access_violation_irq_mask,
  input wire logic read_violation_irq_mask,
  input wire logic flash_irq
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  logic rd_open, prg_open, mod_src, rd_src;
  logic [31:0] prg_word;
  assign rd_open = read_enable_mask[rd_req.addr[17:11]];
  assign prg_open = program_enable_mask[mod_req.addr[17:11]];
  assign mod_src = mod_refused & access_violation_irq_mask;
  assign rd_src = rd_refused & read_violation_irq_mask;
  assign prg_word = program_enable_mask[prot_idx*32+:32];
  a_fetch_open: assert property (
    $rose(rd_req.valid) && rd_req.fetch |=> rd_ack && !rd_refused)
    else $error("fetch not answered openly");
  a_read_block: assert property (
    $rose(rd_req.valid) && !rd_req.fetch
    |=> rd_ack && rd_refused == !$past(rd_open))
    else $error("data read protection wrong");
  a_zero_data: assert property (
    rd_refused |-> rd_ack && rd_data == FPTC_ZERO_WORD)
    else $error("refused read not zero");
  a_prog_block: assert property (
    $rose(mod_req.valid) && mod_req.op != FPTC_OP_NONE && !prg_open
    |=> mod_ack && mod_refused)
    else $error("protected modify not refused");
  a_prog_wait: assert property (
    $rose(mod_req.valid) && mod_req.op != FPTC_OP_NONE && prg_open
    |=> !mod_ack [*8])
    else $error("modify acked too soon");
  a_irq_raise: assert property (
    mod_src || rd_src |=> flash_irq)
    else $error("violation irq missing");
  a_irq_cause: assert property (
    flash_irq |-> $past(mod_src) || $past(rd_src))
    else $error("irq without violation");
  a_mask_no_set: assert property (
    (program_enable_mask & ~$past(program_enable_mask)) == '0
    && (read_enable_mask & ~$past(read_enable_mask)) == '0)
    else $error("protection bit set");
  a_prot_write: assert property (
    prot_we && !prot_read_sel
    |=> program_enable_mask[$past(prot_idx)*32+:32]
    == ($past(prg_word) & $past(prot_wdata)))
    else $error("program mask write wrong");
  a_reload_load: assert property (
    us_reload_we |=> us_cycle_reload == $past(us_reload_wdata))
    else $error("reload not loaded");
endmodule : fptc_ctrl_assertions
bind fptc_ctrl fptc_ctrl_assertions #(
  .ADDR_W(ADDR_W),
  .NPAIRS(NPAIRS)
) fptc_ctrl_assertions_i (
  .clk_sys, .arst_n, .rd_req, .rd_ack, .rd_data, .rd_refused, .mod_req,
  .mod_ack, .mod_refused, .us_reload_we, .us_reload_wdata,
  .us_cycle_reload, .prot_we, .prot_read_sel, .prot_idx, .prot_wdata,
  .program_enable_mask, .read_enable_mask, .access_violation_irq_mask,
  .read_violation_irq_mask, .flash_irq
);
`default_nettype wire

// File: tb/fptc_ctrl_tb.sv
// Purpose: self-checking bench for the flash protect/timing block
// Assumes: 20 MHz clock, reload set to 0x13 before the timed modifies
// Notes: word and mask models kept in the bench
`default_nettype none
module fptc_ctrl_tb
  import fptc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, arst_n = 0, ce = 1, us_reload_we = 0, prot_we = 0;
  logic prot_read_sel = 0, commit_trigger = 0;
  logic access_violation_irq_mask = 0, read_violation_irq_mask = 0;
  logic [7:0] us_reload_wdata = 8'h00, us_cycle_reload, rl = 8'h13;
  logic [1:0] prot_idx = 2'h0;
  logic [31:0] prot_wdata = 32'h0, rd_data;
  logic rd_ack, rd_refused, mod_ack, mod_refused, mod_busy;
  logic commit_busy, flash_irq;
  logic [127:0] program_enable_mask, read_enable_mask;
  logic [127:0] prg_m = '1, rde_m = '1, prg_c = '1, rde_c = '1;
  fptc_rd_req_s rd_req;
  fptc_mod_req_s mod_req;
  logic [31:0] mem [int];
  int fail_count = 0, num_checks = 0;
  always #25 clk_sys = ~clk_sys;
  fptc_ctrl #(.ADDR_W(FPTC_ADDR_W), .NPAIRS(FPTC_NPAIRS)) fptc_ctrl_i (
    .clk_sys, .arst_n, .ce, .rd_req, .rd_ack, .rd_data, .rd_refused,
    .mod_req, .mod_ack, .mod_refused, .mod_busy, .us_reload_we,
    .us_reload_wdata, .us_cycle_reload, .prot_we, .prot_read_sel,
    .prot_idx, .prot_wdata, .commit_trigger, .commit_busy,
    .program_enable_mask, .read_enable_mask, .access_violation_irq_mask,
    .read_violation_irq_mask, .flash_irq
  );
  fptc_bus_model fptc_bus_model_i (
    .clk_sys, .rd_req, .rd_ack, .rd_data, .rd_refused, .mod_req,
    .mod_ack, .mod_refused
  );
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [127:0] e, g);
    num_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk
  task automatic rst();
    @(negedge clk_sys);
    arst_n = 0;
    repeat (5) @(negedge clk_sys);
    arst_n = 1;
    repeat (3) @(negedge clk_sys);
    prg_m = prg_c;
    rde_m = rde_c;
  endtask : rst
  task automatic pw(input logic s, input logic [1:0] i, input logic [31:0] w);
    @(negedge clk_sys);
    prot_we = 1;
    prot_read_sel = s;
    prot_idx = i;
    prot_wdata = w;
    @(negedge clk_sys);
    prot_we = 0;
    if (s) rde_m[i*32+:32] &= w;
    else prg_m[i*32+:32] &= w;
    @(negedge clk_sys);
    chk("prg_mask", prg_m, program_enable_mask);
    chk("rd_mask", rde_m, read_enable_mask);
  endtask : pw
  task automatic rdc(input logic f, input logic [17:0] a,
                     input logic [31:0] e, input logic er);
    logic [31:0] d;
    logic r;
    fptc_bus_model_i.rd(f, a, $urandom % 4, d, r);
    chk("rd_data", e, d);
    chk("rd_refused", er, r);
  endtask : rdc
  task automatic mdc(input fptc_op_e op, input logic [17:0] a,
                     input logic [31:0] dt, input logic er);
    logic r;
    int n, t, base;
    fptc_bus_model_i.md(op, a, dt, r, n);
    chk("mod_refused", er, r);
    base = {a[17:10], 8'h00};
    t = (rl + 1) * (op == FPTC_OP_PROG ? FPTC_PROG_US : FPTC_ERASE_US);
    if (op == FPTC_OP_ERASE) t += 256;
    if (!er) chk("op_time", 1, n >= t && n <= t + 12);
    if (!er && op == FPTC_OP_PROG) mem[a >> 2] = mem[a >> 2] & dt;
    if (!er && op == FPTC_OP_ERASE)
      for (int k = 0; k < 256; k++) mem[base + k] = FPTC_ERASED_WORD;
    @(negedge clk_sys);
    chk("mod_busy", 0, mod_busy);
  endtask : mdc
  initial begin
    logic [17:0] a;
    logic [6:0] b;
    void'($urandom(32'hee7e));
    rst();
    chk("reload", FPTC_USEC_RESET, us_cycle_reload);
    chk("prg_mask", {4{FPTC_PROT_RESET}}, program_enable_mask);
    chk("rd_mask", {4{FPTC_PROT_RESET}}, read_enable_mask);
    @(negedge clk_sys);
    us_reload_we = 1;
    us_reload_wdata = rl;
    @(negedge clk_sys);
    us_reload_we = 0;
    chk("reload", rl, us_cycle_reload);
    a = {8'h00, 8'($urandom), 2'b00};
    mdc(FPTC_OP_ERASE, a, 32'h0, 0);
    rdc(0, a, FPTC_ERASED_WORD, 0);
    mdc(FPTC_OP_PROG, a, $urandom, 0);
    mdc(FPTC_OP_PROG, a, $urandom, 0);
    rdc(0, a, mem[a >> 2], 0);
    mdc(FPTC_OP_ERASE, a, 32'h0, 0);
    rdc(0, a, FPTC_ERASED_WORD, 0);
    for (int c = 0; c < 4; c++) begin
      b = 7'(c * 32 + 1 + $urandom % 31);
      access_violation_irq_mask = 1'($urandom);
      read_violation_irq_mask = 1'($urandom);
      a = {b, 1'b1, 8'($urandom), 2'b00};
      mdc(FPTC_OP_ERASE, a, 32'h0, 0);
      if (!c[0]) pw(0, 2'(c), ~(32'h1 << b[4:0]));
      if (!c[1]) pw(1, 2'(c), ~(32'h1 << b[4:0]));
      rdc(0, a, c[1] ? FPTC_ERASED_WORD : FPTC_ZERO_WORD, !c[1]);
      rdc(1, a, FPTC_ERASED_WORD, 0);
      mdc(FPTC_OP_PROG, a, $urandom, !c[0]);
      rdc(1, a, mem[a >> 2], 0);
      mdc(FPTC_OP_ERASE, {b, 11'h000}, 32'h0, !c[0]);
    end
    rst();
    chk("prg_mask", {4{FPTC_PROT_RESET}}, program_enable_mask);
    chk("rd_mask", {4{FPTC_PROT_RESET}}, read_enable_mask);
    pw(0, 2'h3, 32'hffff_fffe);
    pw(0, 2'h3, 32'hffff_ffff);
    @(negedge clk_sys);
    commit_trigger = 1;
    @(negedge clk_sys);
    commit_trigger = 0;
    for (int i = 0; i < 20 && commit_busy; i++) @(negedge clk_sys);
    chk("commit_busy", 0, commit_busy);
    prg_c = prg_m;
    rst();
    chk("prg_mask", prg_c, program_enable_mask);
    mdc(FPTC_OP_PROG, {7'd96, 11'h000}, 32'h0, 1);
    tally_and_finish();
  end
  initial begin
    #2000000;
    fail_count++;
    tally_and_finish();
  end
endmodule : fptc_ctrl_tb
`default_nettype wire
